// >>> common/converter_trim_dither_cfg.svh
// register offsets, field positions and reset values of the trim and dither bank
`ifndef CONVERTER_TRIM_DITHER_CFG_SVH
`define CONVERTER_TRIM_DITHER_CFG_SVH

// register indices; byte address is four times the index
`define IDX_CHAN_A_AMP 10'h07a
`define IDX_CHAN_B_AMP 10'h07b
`define IDX_REF_VOLT 10'h07c
`define IDX_CHAN_A_TERM 10'h07e
`define IDX_CHAN_B_TERM 10'h07f
`define IDX_NOISE_CTRL 10'h09d
`define IDX_LOW_BIT_CTRL 10'h160

// reset values before the fuse load
`define RST_TRIM 8'h00
`define RST_NOISE_CTRL 8'h01
`define RST_LOW_BIT_CTRL 8'h00

// field positions
`define REF_VOLT_MSB 3
`define NOISE_ON_BIT 0
`define NOISE_LEVEL_BIT 1
`define ROUND_ERR_BIT 2
`define MARKER_ON_BIT 0

// sample width
`define SAMPLE_W 12

`endif

// >>> common/converter_trim_dither_pkg.sv
// types shared by the trim and dither register bank
package converter_trim_dither_pkg;

  // factory fuse values presented to the bank
  typedef struct packed {
    logic [7:0] chan_a_amp;
    logic [7:0] chan_b_amp;
    logic [3:0] ref_volt;
    logic [7:0] chan_a_term;
    logic [7:0] chan_b_term;
  } fuse_t;

  // trim values driven to the analog front end
  typedef struct packed {
    logic [7:0] chan_a_amp;
    logic [7:0] chan_b_amp;
    logic [3:0] ref_volt;
    logic [7:0] chan_a_term;
    logic [7:0] chan_b_term;
  } trim_t;

  // noise injection controls
  typedef struct packed {
    logic rounding_error_placement;
    logic noise_injection_level;
    logic noise_injection_on;
  } noise_t;

  // one output sample with its marker
  typedef struct packed {
    logic valid;
    logic marker;
    logic [11:0] data;
  } sample_t;

endpackage

// >>> hdl/converter_trim_dither_regs.sv
// ahb-lite register bank for converter trims, noise injection and sample low-bit marker
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "converter_trim_dither_cfg.svh"

module converter_trim_dither_regs
  import converter_trim_dither_pkg::*;
(
  input wire logic hclk, // bus clock, 50 MHz
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire fuse_t fuse, // factory fuse values
  output trim_t trim, // trims to the front end
  output noise_t noise, // noise injection controls
  input wire sample_t sample_in, // raw converter sample
  input wire logic marker_in, // timestamp marker aligned with sample_in
  output sample_t sample_out // sample with optional marker
);

  // address phase capture
  logic wr_pend_r;
  logic rd_pend_r;
  logic [9:0] idx_r;
  logic [31:0] rdata_r;

  // stored registers
  logic [7:0] chan_a_amp_r;
  logic [7:0] chan_b_amp_r;
  logic [7:0] ref_volt_r;
  logic [7:0] chan_a_term_r;
  logic [7:0] chan_b_term_r;
  logic [7:0] noise_ctrl_r;
  logic [7:0] low_bit_ctrl_r;

  // fuse load pending after reset release
  logic fuse_load_r;

  // sample pipeline, one register per field so each has its own process
  logic valid_r;
  logic marker_r;
  logic [`SAMPLE_W-1:0] data_r;
  logic marker_on;

  // decoded bus terms
  logic take;
  logic [9:0] addr_idx;
  logic wr_now;

  // one write strobe per register, high in that register's write data phase
  logic we_chan_a_amp;
  logic we_chan_b_amp;
  logic we_ref_volt;
  logic we_chan_a_term;
  logic we_chan_b_term;
  logic we_noise_ctrl;
  logic we_low_bit_ctrl;

  // next values of the stored registers and of the read data
  logic [7:0] chan_a_amp_nxt;
  logic [7:0] chan_b_amp_nxt;
  logic [7:0] ref_volt_nxt;
  logic [7:0] chan_a_term_nxt;
  logic [7:0] chan_b_term_nxt;
  logic [7:0] noise_ctrl_nxt;
  logic [7:0] low_bit_ctrl_nxt;
  logic [31:0] rdata_nxt;

  // word index of a byte address
  function automatic logic [9:0] word_index(input logic [31:0] a);
    word_index = a[11:2];
  endfunction

  // true when a write in its data phase targets a given index
  function automatic logic hit(input logic wr, input logic [9:0] cur, input logic [9:0] tgt);
    hit = wr && (cur == tgt);
  endfunction

  // next value of a fuse-loaded trim: a bus write beats the fuse load
  function automatic logic [7:0] trim_next(
    input logic we,
    input logic [7:0] wd,
    input logic load,
    input logic [7:0] fv,
    input logic [7:0] cur
  );
    logic [7:0] n;
    n = cur;
    if (we) begin
      n = wd;
    end else if (load) begin
      n = fv;
    end
    trim_next = n;
  endfunction

  // next value of a register that only software writes
  function automatic logic [7:0] ctrl_next(
    input logic we,
    input logic [7:0] wd,
    input logic [7:0] cur
  );
    ctrl_next = we ? wd : cur;
  endfunction

  // read value of an index, unmapped reads zero
  function automatic logic [31:0] read_mux(
    input logic [9:0] i,
    input logic [7:0] a_amp,
    input logic [7:0] b_amp,
    input logic [7:0] rv,
    input logic [7:0] a_term,
    input logic [7:0] b_term,
    input logic [7:0] nc,
    input logic [7:0] lb
  );
    logic [7:0] v;
    v = 8'h00;
    if (i == `IDX_CHAN_A_AMP) begin
      v = a_amp;
    end else if (i == `IDX_CHAN_B_AMP) begin
      v = b_amp;
    end else if (i == `IDX_REF_VOLT) begin
      v = rv;
    end else if (i == `IDX_CHAN_A_TERM) begin
      v = a_term;
    end else if (i == `IDX_CHAN_B_TERM) begin
      v = b_term;
    end else if (i == `IDX_NOISE_CTRL) begin
      v = nc;
    end else if (i == `IDX_LOW_BIT_CTRL) begin
      v = lb;
    end
    read_mux = {24'h000000, v};
  endfunction

  // accept a nonseq or seq transfer when the bus is ready
  assign take = hsel && htrans[1] && hready;
  assign addr_idx = word_index(haddr);
  assign wr_now = wr_pend_r;

  // zero-wait slave, okay response only; the bank never stretches a transfer,
  // so every access finishes one cycle after its address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // write strobes from the captured data phase index
  always_comb begin
    we_chan_a_amp = hit(wr_now, idx_r, `IDX_CHAN_A_AMP);
    we_chan_b_amp = hit(wr_now, idx_r, `IDX_CHAN_B_AMP);
    we_ref_volt = hit(wr_now, idx_r, `IDX_REF_VOLT);
    we_chan_a_term = hit(wr_now, idx_r, `IDX_CHAN_A_TERM);
    we_chan_b_term = hit(wr_now, idx_r, `IDX_CHAN_B_TERM);
    we_noise_ctrl = hit(wr_now, idx_r, `IDX_NOISE_CTRL);
    we_low_bit_ctrl = hit(wr_now, idx_r, `IDX_LOW_BIT_CTRL);
  end

  // next values; the reference adjust keeps its reserved nibble on a fuse load
  always_comb begin
    chan_a_amp_nxt = trim_next(we_chan_a_amp, hwdata[7:0], fuse_load_r, fuse.chan_a_amp,
      chan_a_amp_r);
    chan_b_amp_nxt = trim_next(we_chan_b_amp, hwdata[7:0], fuse_load_r, fuse.chan_b_amp,
      chan_b_amp_r);
    ref_volt_nxt = trim_next(we_ref_volt, hwdata[7:0], fuse_load_r,
      {ref_volt_r[7:4], fuse.ref_volt}, ref_volt_r);
    chan_a_term_nxt = trim_next(we_chan_a_term, hwdata[7:0], fuse_load_r, fuse.chan_a_term,
      chan_a_term_r);
    chan_b_term_nxt = trim_next(we_chan_b_term, hwdata[7:0], fuse_load_r, fuse.chan_b_term,
      chan_b_term_r);
    noise_ctrl_nxt = ctrl_next(we_noise_ctrl, hwdata[7:0], noise_ctrl_r);
    low_bit_ctrl_nxt = ctrl_next(we_low_bit_ctrl, hwdata[7:0], low_bit_ctrl_r);
  end

  // address phase: a taken transfer opens a data phase on the next cycle;
  // hsize is not decoded, every access is handled as one whole word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= take && hwrite;
      rd_pend_r <= take && !hwrite;
    end
  end

  // address phase: remember the target index until the next taken transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r <= 10'h000;
    end else if (take) begin
      idx_r <= addr_idx;
    end
  end

  // read data is looked up in the address phase and cleared after the data phase,
  // so stale register contents do not linger on the bus;
  // a read that overlaps a write data phase to the same register sees the old value
  always_comb begin
    rdata_nxt = rdata_r;
    if (take && !hwrite) begin
      rdata_nxt = read_mux(addr_idx, chan_a_amp_r, chan_b_amp_r, ref_volt_r,
                           chan_a_term_r, chan_b_term_r, noise_ctrl_r, low_bit_ctrl_r);
    end else if (rd_pend_r) begin
      rdata_nxt = 32'h00000000;
    end
  end

  // read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // fuse load runs on the first edge after reset release; the fuse inputs must
  // be settled by then, and a bus write in that same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_load_r <= 1'b1;
    end else begin
      fuse_load_r <= 1'b0;
    end
  end

  // channel a amplitude adjust
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_a_amp_r <= `RST_TRIM;
    end else begin
      chan_a_amp_r <= chan_a_amp_nxt;
    end
  end

  // channel b amplitude adjust
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_b_amp_r <= `RST_TRIM;
    end else begin
      chan_b_amp_r <= chan_b_amp_nxt;
    end
  end

  // reference voltage adjust; reserved upper nibble is stored as written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_volt_r <= `RST_TRIM;
    end else begin
      ref_volt_r <= ref_volt_nxt;
    end
  end

  // channel a termination adjust
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_a_term_r <= `RST_TRIM;
    end else begin
      chan_a_term_r <= chan_a_term_nxt;
    end
  end

  // channel b termination adjust
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_b_term_r <= `RST_TRIM;
    end else begin
      chan_b_term_r <= chan_b_term_nxt;
    end
  end

  // noise injection control, reset value turns injection on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      noise_ctrl_r <= `RST_NOISE_CTRL;
    end else begin
      noise_ctrl_r <= noise_ctrl_nxt;
    end
  end

  // sample low-bit control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_bit_ctrl_r <= `RST_LOW_BIT_CTRL;
    end else begin
      low_bit_ctrl_r <= low_bit_ctrl_nxt;
    end
  end

  // trim values to the front end; reserved bits stay inside the bank
  // and never reach the analog side
  assign trim.chan_a_amp = chan_a_amp_r;
  assign trim.chan_b_amp = chan_b_amp_r;
  assign trim.ref_volt = ref_volt_r[`REF_VOLT_MSB:0];
  assign trim.chan_a_term = chan_a_term_r;
  assign trim.chan_b_term = chan_b_term_r;

  // noise injection fields, each a single bit of the control register;
  // the reserved upper bits are storage only
  assign noise.noise_injection_on = noise_ctrl_r[`NOISE_ON_BIT];
  assign noise.noise_injection_level = noise_ctrl_r[`NOISE_LEVEL_BIT];
  assign noise.rounding_error_placement = noise_ctrl_r[`ROUND_ERR_BIT];

  // marker enable decoded once from the low-bit control
  assign marker_on = low_bit_ctrl_r[`MARKER_ON_BIT];

  // sample valid, one register stage like the data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= sample_in.valid;
    end
  end

  // marker takes the same single stage as the data so their latency matches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      marker_r <= 1'b0;
    end else begin
      marker_r <= marker_in;
    end
  end

  // sample data, low bit replaced by the marker when enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= '0;
    end else if (marker_on) begin
      data_r <= {sample_in.data[`SAMPLE_W-1:1], marker_in};
    end else begin
      data_r <= sample_in.data;
    end
  end

  // output sample; the unused marker field of the raw sample is dropped
  assign sample_out = '{valid: valid_r, marker: marker_r, data: data_r};

endmodule

// >>> bench/converter_trim_dither_regs_sva.sv
// checker for bus answers, trim and noise updates and the sample path
`timescale 1ns/10ps
`include "converter_trim_dither_cfg.svh"
module converter_trim_dither_regs_chk
  import converter_trim_dither_pkg::*;
(
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // ready in
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic [31:0] hrdata, // read data
  input wire trim_t trim, // trims
  input wire noise_t noise, // noise controls
  input wire sample_t sample_in, // raw sample
  input wire logic marker_in, // marker
  input wire sample_t sample_out // sample out
);
  logic wa_r;
  logic [9:0] ia_r;
  logic up_r;
  wire take = hsel & htrans[1] & hready;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // remember a write data phase, its index, and the first edge past reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_r <= 1'b0;
      ia_r <= 10'h000;
      up_r <= 1'b0;
    end else begin
      wa_r <= take & hwrite;
      ia_r <= haddr[11:2];
      up_r <= 1'b1;
    end
  end
  AST_READY: assert property (hreadyout)
    else $error("ready dropped");
  AST_OKAY: assert property (!hresp)
    else $error("response not okay");
  AST_HIGH_ZERO: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_NOISE_WR: assert property (
    wa_r && ia_r == `IDX_NOISE_CTRL |=> noise == $past(hwdata[2:0]))
    else $error("noise write lost");
  AST_NOISE_HOLD: assert property (
    !(wa_r && ia_r == `IDX_NOISE_CTRL) |=> $stable(noise))
    else $error("noise changed without write");
  AST_NOISE_RD: assert property (
    take && !hwrite && haddr[11:2] == `IDX_NOISE_CTRL |=> hrdata[2:0] == $past(noise))
    else $error("noise read wrong");
  AST_AMP_A_WR: assert property (
    wa_r && ia_r == `IDX_CHAN_A_AMP |=> trim.chan_a_amp == $past(hwdata[7:0]))
    else $error("amplitude write lost");
  AST_REF_WR: assert property (
    wa_r && ia_r == `IDX_REF_VOLT |=> trim.ref_volt == $past(hwdata[3:0]))
    else $error("reference write lost");
  AST_SAMPLE: assert property (up_r |-> sample_out.valid == $past(sample_in.valid) &&
    sample_out.data[11:1] == $past(sample_in.data[11:1]))
    else $error("sample path wrong");
  AST_MARKER: assert property (up_r |-> sample_out.marker == $past(marker_in))
    else $error("marker delay wrong");
  COV_NOISE_WR: cover property (wa_r && ia_r == `IDX_NOISE_CTRL);
  COV_READ: cover property (take && !hwrite);
  COV_MARK: cover property (sample_out.marker && sample_out.data[0]);
endmodule

bind converter_trim_dither_regs converter_trim_dither_regs_chk chk (.*);

// >>> bench/converter_trim_dither_regs_bench.sv
// self-checking bench for the trim and noise register bank
`timescale 1ns/10ps
`include "converter_trim_dither_cfg.svh"
module converter_trim_dither_regs_bench
  import converter_trim_dither_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, marker_in, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] seed = 32'h0000003f;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hready;
  fuse_t fuse;
  trim_t trim;
  noise_t noise;
  sample_t sample_in, sample_out;
  int error_cnt, compares;
  logic [9:0] idx [7] = '{`IDX_CHAN_A_AMP, `IDX_CHAN_B_AMP, `IDX_REF_VOLT, `IDX_CHAN_A_TERM,
    `IDX_CHAN_B_TERM, `IDX_NOISE_CTRL, `IDX_LOW_BIT_CTRL};
  converter_trim_dither_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .fuse(fuse), .trim(trim),
    .noise(noise), .sample_in(sample_in), .marker_in(marker_in), .sample_out(sample_out));
  // clock at 50 MHz
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // xorshift source of stimulus
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // value a register shows right after reset
  function automatic logic [7:0] exp_rst(input int k, input fuse_t f);
    case (k)
      0: return f.chan_a_amp;
      1: return f.chan_b_amp;
      2: return {4'h0, f.ref_volt};
      3: return f.chan_a_term;
      4: return f.chan_b_term;
      5: return `RST_NOISE_CTRL;
      default: return `RST_LOW_BIT_CTRL;
    endcase
  endfunction
  // software keeps reserved bits at zero
  function automatic logic [7:0] rsv_mask(input int k, input logic [7:0] d);
    case (k)
      2: return d & 8'h0f;
      5: return d & 8'h07;
      6: return d & 8'h01;
      default: return d;
    endcase
  endfunction
  // sample one register stage later, marker on the low bit when enabled
  function automatic sample_t exp_s(input sample_t s, input logic mk, input logic on);
    exp_s = s;
    exp_s.marker = mk;
    if (on) exp_s.data[0] = mk;
  endfunction
  task automatic give_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // wait for an edge with ready high, bounded
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h00000, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    rdy();
    q = hrdata;
  endtask
  initial begin
    logic [31:0] q;
    logic [7:0] v [7];
    sample_t ps;
    logic pm;
    {hsel, hwrite, marker_in, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    sample_in = '0;
    fuse = '0;
    hresetn = 1'b0;
    // second pass is a reset in mid-run with fresh fuse values
    for (int p = 0; p < 2; p++) begin
      @(posedge hclk);
      fuse <= fuse_t'(36'({rnd(), rnd()}));
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      chk("trim", fuse, trim);
      chk("noise", 36'h1, 36'(noise));
      for (int k = 0; k < 7; k++) begin
        xfer(1'b0, idx[k], 8'h00, q);
        chk("reset", 36'(exp_rst(k, fuse)), 36'(q));
      end
      for (int k = 0; k < 7; k++) begin
        v[k] = rsv_mask(k, 8'(rnd()));
        xfer(1'b1, idx[k], v[k], q);
      end
      for (int k = 0; k < 7; k++) begin
        xfer(1'b0, idx[k], 8'h00, q);
        chk("readback", 36'(v[k]), 36'(q));
      end
      chk("trim", {v[0], v[1], v[2][3:0], v[3], v[4]}, trim);
      for (int c = 0; c < 8; c++) begin
        xfer(1'b1, `IDX_NOISE_CTRL, 8'(c), q);
        #1;
        chk("noise", 36'(c), 36'(noise));
      end
      xfer(1'b1, 10'h07d, 8'h5a, q);
      xfer(1'b0, 10'h07d, 8'h00, q);
      chk("unmapped", 36'h0, 36'(q));
      for (int m = 0; m < 2; m++) begin
        xfer(1'b1, `IDX_LOW_BIT_CTRL, 8'(m), q);
        for (int j = 0; j < 20; j++) begin
          @(posedge hclk);
          q = rnd();
          sample_in <= q[13:0];
          marker_in <= q[14];
          #1;
          if (j > 0) chk("sample", 36'(exp_s(ps, pm, m[0])), 36'(sample_out));
          ps = q[13:0];
          pm = q[14];
        end
      end
    end
    give_verdict();
  end
endmodule
